// ==== tb.sv ====
// Self-checking bench for the exception summary register
// Assumes tes_cfg.svh, tes_pkg and tes_exc_summary are compiled first
`timescale 1ns/1ps
`include "tes_cfg.svh"
module tb;
    import tes_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        trap_deliver = 1'b0;
    tes_class_t  trap_class = TES_CLS_ARITH;
    tes_mem_t    mem_kind = TES_MEM_LOAD;
    logic [4:0]  dest_reg = 5'h00;
    logic [4:0]  src_reg = 5'h00;
    logic [5:0]  set_status = 6'h00;
    logic [4:0]  fp_causes = 5'h00;
    logic [3:0]  flags = 4'h0;
    logic        sw_qualifier = 1'b0;
    logic [63:0] exception_summary;
    logic [63:0] q[$];
    logic [63:0] cur;
    logic        tk = 1'b0;
    logic        rs = 1'b1;
    int          mismatches = 0;
    int          n_tests = 0;
    int          seed = 97831;
    tes_exc_summary tes_exc_summary_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .trap_deliver(trap_deliver), .trap_class(trap_class), .mem_kind(mem_kind),
        .dest_reg(dest_reg), .src_reg(src_reg), .set_status(set_status),
        .addr_sext_err(flags[0]), .fault_in_va(flags[1]), .int_unit_ovf(flags[2]),
        .cvt_int_ovf(flags[3]), .fp_causes(fp_causes), .sw_qualifier(sw_qualifier),
        .exception_summary(exception_summary));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        tk <= clk_en & trap_deliver & ~rst;
        rs <= rst;
    end
    // Expected image of the present trap inputs
    function automatic logic [63:0] img();
        logic [63:0] v;
        v = 64'h0000_0000_0000_0000;
        v[0] = sw_qualifier;
        if (trap_class == TES_CLS_ARITH) begin
            v[63:42] = {{16{set_status[5]}}, set_status};
            v[12:8] = dest_reg;
            v[7:1] = {flags[2], flags[2] | flags[3], fp_causes};
        end else if (trap_class == TES_CLS_ISTREAM) begin
            v[41] = flags[0];
            v[13] = flags[1];
        end else if (trap_class == TES_CLS_DSTREAM) begin
            v[12:8] = (mem_kind == TES_MEM_STORE) ? src_reg : dest_reg;
        end
        return v;
    endfunction : img
    task automatic chk(input logic [63:0] e);
        n_tests++;
        if (exception_summary !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, exception_summary, e);
        end
    endtask : chk
    // Random deliveries; force_dlv keeps a trap every cycle
    task automatic run(input int n, input bit force_dlv, input bit rst_mid);
        logic [31:0] rnd;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            #1;
            rnd = $random(seed);
            {flags, sw_qualifier, fp_causes, set_status} = rnd[15:0];
            rnd = $random(seed);
            dest_reg = rnd[4:0];
            src_reg = rnd[9:5];
            trap_class = tes_class_t'(rnd[11:10]);
            mem_kind = tes_mem_t'(rnd[12]);
            clk_en = force_dlv || (rnd[15:13] != 3'h0);
            trap_deliver = force_dlv || rnd[16];
            rst = rst_mid && (i > n / 2) && (i < n / 2 + 3);
            if (clk_en && trap_deliver && !rst) q.push_back(img());
        end
    endtask : run
    initial forever begin
        @(posedge core_clk);
        #2;
        if (rs) cur = 64'h0;
        else if (tk) cur = q.pop_front();
        chk(cur);
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        #40;
        run(400, 1'b0, 1'b0);
        $display("test random_traffic done");
        run(40, 1'b0, 1'b1);
        $display("test reset_mid_run done");
        run(60, 1'b1, 1'b0);
        $display("test back_to_back done");
        run(2, 1'b0, 1'b0);
        stop_test();
    end
    initial begin
        #(4 * 2000);
        mismatches++;
        stop_test();
    end
endmodule : tb

// ==== tes_cfg.svh ====
// Field positions and encodings of the exception summary register
// Assumes inclusion by bare name from the package and design modules
`ifndef TES_CFG_SVH
`define TES_CFG_SVH
`define TES_WIDTH          64
`define TES_SEXT_HI        63
`define TES_SEXT_LO        48
`define TES_SEXT_W         16
`define TES_SET_HI         47
`define TES_SET_LO         42
`define TES_SET_INTOVF_BIT 47
`define TES_ADDR_SEXT_BIT  41
`define TES_RSV_HI         40
`define TES_RSV_LO         14
`define TES_RSV_W          27
`define TES_FAULT_LOC_BIT  13
`define TES_REG_HI         12
`define TES_REG_LO         8
`define TES_INT_BIT        7
`define TES_OVF_ANY_BIT    6
`define TES_FP_HI          5
`define TES_FP_LO          1
`define TES_SWCOMP_BIT     0
`define TES_CAUSE_W        5
`define TES_REG_W          5
`define TES_SET_W          6
`define TES_ZERO64         64'h0000_0000_0000_0000
`define TES_ZERO5          5'h00
`endif

// ==== tes_exc_summary.sv ====
// Exception summary register captured at trap delivery, read-only
// Assumes trap sources present all trap details with trap_deliver
`timescale 1ns/1ps
`include "tes_cfg.svh"
// Behaviour
// RULE1 - Capture trap details at delivery; no writes
// RULE2 - Software reads in first handler fetch block
// RULE3 - Arithmetic, istream violation, dstream classes captured
// RULE4 - Upper sixteen bits copy bit 47
// RULE5 - Bits 47..42 request status bit setting
// RULE6 - Bit 41 flags bad address sign extension
// RULE7 - Bit 13 selects which address register
// RULE8 - Dstream: store source, load destination register
// RULE9 - Arithmetic: operate destination register
// RULE10 - Register field arbitrary for other traps
// RULE11 - Bit 7 integer-unit overflow versus FP
// RULE12 - Bit 6 convert or integer overflow
// RULE13 - Bits 5..1 FP trap causes
// RULE14 - Bit 0 software completion qualifier
// RULE15 - Bits 40..14 read zero
// RULE16 - Value held until next delivery
module tes_exc_summary
    import tes_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    input  wire logic                     trap_deliver,
    input  wire tes_class_t               trap_class,
    input  wire tes_mem_t                 mem_kind,
    input  wire logic [`TES_REG_W-1:0]    dest_reg,
    input  wire logic [`TES_REG_W-1:0]    src_reg,
    input  wire logic [`TES_SET_W-1:0]    set_status,
    input  wire logic                     addr_sext_err,
    input  wire logic                     fault_in_va,
    input  wire logic                     int_unit_ovf,
    input  wire logic                     cvt_int_ovf,
    input  wire logic [`TES_CAUSE_W-1:0]  fp_causes,
    input  wire logic                     sw_qualifier,
    output logic      [`TES_WIDTH-1:0]    exception_summary
);
    logic [`TES_WIDTH-1:0] exception_summary_r;
    logic [`TES_WIDTH-1:0] exception_summary_nxt;
    wire logic [`TES_REG_W-1:0] reg_field;
    wire logic is_arith;
    wire logic is_istream;
    wire logic set_int_ovf;

    tes_reg_sel u_reg_sel (
        .trap_class (trap_class),
        .mem_kind   (mem_kind),
        .dest_reg   (dest_reg),
        .src_reg    (src_reg),
        .reg_field  (reg_field)
    );

    assign is_arith = (trap_class == TES_CLS_ARITH);                    // RULE3
    assign is_istream  = (trap_class == TES_CLS_ISTREAM);               // RULE3
    assign set_int_ovf = is_arith & set_status[`TES_SET_W-1];

    // Assemble image of the trapping instruction
    assign exception_summary_nxt = {
        {`TES_SEXT_W{set_int_ovf}},                                     // RULE4
        set_int_ovf,
        is_arith ? set_status[`TES_SET_W-2:0] : `TES_ZERO5,             // RULE5
        is_istream & addr_sext_err,                                     // RULE6
        {`TES_RSV_W{1'b0}},                                             // RULE15
        is_istream & fault_in_va,                                       // RULE7
        reg_field,                                                      // RULE8
        is_arith & int_unit_ovf,                                        // RULE11
        is_arith & (int_unit_ovf | cvt_int_ovf),                        // RULE12
        is_arith ? fp_causes : `TES_ZERO5,                              // RULE13
        sw_qualifier                                                    // RULE14
    };

    always_ff @(posedge core_clk) begin
        if (rst) begin
            exception_summary_r <= `TES_ZERO64;
        end else if (clk_en && trap_deliver) begin                      // RULE16
            exception_summary_r <= exception_summary_nxt;               // RULE1
        end
    end

    assign exception_summary = exception_summary_r;

    chk_hold_value : assert property (@(posedge core_clk) disable iff (rst) // RULE16
        !(clk_en && trap_deliver) |=> $stable(exception_summary))
        else $error("summary changed without trap delivery");
    chk_capture_now : assert property (@(posedge core_clk) disable iff (rst) // RULE1
        (clk_en && trap_deliver) |=> exception_summary == $past(exception_summary_nxt))
        else $error("summary not captured at delivery");
    chk_sext_copy : assert property (@(posedge core_clk) disable iff (rst) // RULE4
        exception_summary[`TES_SEXT_HI:`TES_SEXT_LO] ==
        {`TES_SEXT_W{exception_summary[`TES_SET_INTOVF_BIT]}})
        else $error("upper bits not sign extension");
    chk_reserved_zero : assert property (@(posedge core_clk) disable iff (rst) // RULE15
        exception_summary[`TES_RSV_HI:`TES_RSV_LO] == {`TES_RSV_W{1'b0}})
        else $error("reserved bits nonzero");
    chk_store_src : assert property (@(posedge core_clk) disable iff (rst) // RULE8
        (clk_en && trap_deliver && trap_class == TES_CLS_DSTREAM && mem_kind == TES_MEM_STORE)
        |=> exception_summary[`TES_REG_HI:`TES_REG_LO] == $past(src_reg))
        else $error("store source register not captured");
    chk_arith_dest : assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (clk_en && trap_deliver && trap_class == TES_CLS_ARITH)
        |=> exception_summary[`TES_REG_HI:`TES_REG_LO] == $past(dest_reg))
        else $error("operate destination not captured");
    chk_va_select : assert property (@(posedge core_clk) disable iff (rst) // RULE7
        (clk_en && trap_deliver && trap_class == TES_CLS_ISTREAM)
        |=> exception_summary[`TES_FAULT_LOC_BIT] == $past(fault_in_va))
        else $error("address location bit wrong");
    chk_iov_int : assert property (@(posedge core_clk) disable iff (rst) // RULE12
        exception_summary[`TES_INT_BIT] |-> exception_summary[`TES_OVF_ANY_BIT])
        else $error("integer overflow without overflow bit");
    chk_swc_bit : assert property (@(posedge core_clk) disable iff (rst) // RULE14
        (clk_en && trap_deliver) |=> exception_summary[`TES_SWCOMP_BIT] == $past(sw_qualifier))
        else $error("software completion bit wrong");
endmodule : tes_exc_summary

// ==== tes_pkg.sv ====
// Types shared by the exception summary design files
// Assumes tes_cfg.svh is on the include path
`include "tes_cfg.svh"
package tes_pkg;
    typedef enum logic [1:0] {
        TES_CLS_ARITH,
        TES_CLS_ISTREAM,
        TES_CLS_DSTREAM,
        TES_CLS_OTHER
    } tes_class_t;
    typedef enum logic {
        TES_MEM_LOAD,
        TES_MEM_STORE
    } tes_mem_t;
endpackage : tes_pkg

// ==== tes_reg_sel.sv ====
// Register specifier selection for a trapping instruction
// Assumes the trap source supplies both instruction specifiers
`timescale 1ns/1ps
`include "tes_cfg.svh"
module tes_reg_sel
    import tes_pkg::*;
(
    input  wire tes_class_t             trap_class,
    input  wire tes_mem_t               mem_kind,
    input  wire logic [`TES_REG_W-1:0]  dest_reg,
    input  wire logic [`TES_REG_W-1:0]  src_reg,
    output logic      [`TES_REG_W-1:0]  reg_field
);
    wire logic is_store;
    wire logic is_arith;
    wire logic is_dstream;
    assign is_store   = (mem_kind == TES_MEM_STORE);
    assign is_arith   = (trap_class == TES_CLS_ARITH);
    assign is_dstream = (trap_class == TES_CLS_DSTREAM);
    // Store gives source, load and operate give destination
    assign reg_field  = (is_dstream && is_store) ? src_reg :            // RULE8
                        (is_arith || is_dstream) ? dest_reg :           // RULE9
                        `TES_ZERO5;                                     // RULE10
endmodule : tes_reg_sel
